// ### src/i2m_master.sv
/*
 * I2C master, single-master system: Start generation and byte transmit
 * with acknowledge capture, registers on Avalon-MM with waitrequest.
 * Assumes open-drain pads resolved outside; pins sampled synchronously.
 */
// Summary of operation
// - Bus clock equals clock over 2(reload+2).
// - Transmit write during Start is dropped, collision.
// - Start request bit 0 launches a Start.
// - Start seen sets bit 3, clears bit 4.
// - Start done clears request, raises interrupt.
// - After Start, data and clock held low.
// - Low five control bits frozen while busy.
// - Transmit write sets full flag, starts shifting.
// - Eight bits shifted, changed after clock falls.
// - Eighth fall clears full, releases data.
// - Ninth fall samples acknowledge into bit 15.
// - After ninth clock interrupt, then idle.
// - Byte sent verbatim, content not checked.
// - Write during shifting dropped; software clears collision.
// - Baud counter stops at zero, reloads on high clock.
// - Baud count decrements twice per instruction cycle.
`timescale 1ns/10ps
`default_nettype none
module i2m_master
   import i2m_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Bus clock pin
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // Bus data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Master event interrupt, one-cycle pulse
   output logic master_event_interrupt
);

   // Whole state of the block
   typedef struct packed {
      i2m_state_t state;
      logic [15:0] control_word; // Bit 0 is start request
      logic [15:0] baud_reload_value;
      logic [7:0] transmit_buffer;
      logic [7:0] shift; // Outgoing bits, MSB first
      logic [3:0] bit_cnt; // Clocks done in this byte
      logic ack_flag;
      logic txbusy_flag;
      logic coll_flag;
      logic stop_seen;
      logic start_seen;
      logic full_flag;
      logic scl_prev; // For bus monitor edges
      logic sda_prev;
      logic [31:0] rdata;
      logic ack_done; // Access answered this cycle
      logic irq;
      i2m_pins_t pins;
   } i2m_top_t;

   i2m_top_t cur;
   i2m_top_t next_cur;
   logic brg_load; // Restart the baud generator
   logic brg_tick; // One baud period elapsed
   logic busy; // Master logic active
   logic acc; // First cycle of an access, read data captured
   logic wr_acc; // Write takes effect as waitrequest drops
   logic [15:0] status_word;

   // Baud generator; the reload at each phase start gives
   // a half period of reload+2 clocks
   i2m_baud u_baud (
      .clk(clk),
      .nrst(nrst),
      .load(brg_load),
      .reload(cur.baud_reload_value),
      .timeout(brg_tick)
   );

   // Gathered status view
   always_comb begin
      status_word = 16'h0000;
      status_word[STAT_ACK_BIT] = cur.ack_flag;
      status_word[STAT_TXBUSY_BIT] = cur.txbusy_flag;
      status_word[STAT_COLL_BIT] = cur.coll_flag;
      status_word[STAT_STOP_SEEN_BIT] = cur.stop_seen;
      status_word[STAT_START_SEEN_BIT] = cur.start_seen;
      status_word[STAT_FULL_BIT] = cur.full_flag;
   end

   assign busy = (cur.state != ST_IDLE) && (cur.state != ST_HOLD);
   // One wait cycle per access keeps read data registered
   assign acc = (read || write) && !cur.ack_done;
   // Writes land only at the edge where the master sees waitrequest low
   assign wr_acc = write && cur.ack_done;

   // Next-state logic for bus slave, sequencer and monitor
   always_comb begin
      next_cur = cur;
      brg_load = 1'b0;
      next_cur.irq = 1'b0;
      next_cur.ack_done = acc;
      next_cur.scl_prev = scl_in;
      next_cur.sda_prev = sda_in;

      // Bus monitor: Start is data falling while clock high
      if (cur.scl_prev && scl_in && cur.sda_prev && !sda_in) begin
         next_cur.start_seen = 1'b1;
         next_cur.stop_seen = 1'b0;
      end else if (cur.scl_prev && scl_in && !cur.sda_prev && sda_in) begin
         next_cur.stop_seen = 1'b1;
         next_cur.start_seen = 1'b0;
      end

      // Register reads
      if (acc && read) begin
         case (address)
            ADDR_CONTROL: next_cur.rdata = {16'h0000, cur.control_word};
            ADDR_STATUS: next_cur.rdata = {16'h0000, status_word};
            ADDR_BAUD: next_cur.rdata = {16'h0000, cur.baud_reload_value};
            ADDR_TRANSMIT: next_cur.rdata = {24'h000000, cur.transmit_buffer};
            default: next_cur.rdata = 32'h00000000; // Unmapped reads zero
         endcase
      end

      // Register writes
      if (wr_acc) begin
         case (address)
            ADDR_CONTROL: begin
               if (byteenable[1]) begin
                  next_cur.control_word[15:8] = writedata[15:8];
               end
               if (byteenable[0]) begin
                  next_cur.control_word[7:CON_LOCK_BITS] =
                     writedata[7:CON_LOCK_BITS];
                  // Low bits only while idle; no queued events
                  if (!busy) begin
                     next_cur.control_word[CON_LOCK_BITS-1:0] =
                        writedata[CON_LOCK_BITS-1:0];
                  end
               end
            end
            ADDR_STATUS: begin
               // Only the collision flag is software clearable
               if (byteenable[0] && !writedata[STAT_COLL_BIT]) begin
                  next_cur.coll_flag = 1'b0;
               end
            end
            ADDR_BAUD: begin
               if (byteenable[0]) begin
                  next_cur.baud_reload_value[7:0] = writedata[7:0];
               end
               if (byteenable[1]) begin
                  next_cur.baud_reload_value[15:8] = writedata[15:8];
               end
            end
            ADDR_TRANSMIT: begin
               if (byteenable[0]) begin
                  if (busy || cur.control_word[CON_START_BIT]) begin
                     // Set placed after clear so it wins
                     next_cur.coll_flag = 1'b1;
                  end else begin
                     // Byte kept as written
                     next_cur.transmit_buffer = writedata[7:0];
                     next_cur.shift = writedata[7:0];
                     next_cur.full_flag = 1'b1;
                     next_cur.txbusy_flag = 1'b1;
                     next_cur.bit_cnt = 4'h0;
                     next_cur.state = ST_LOW;
                     brg_load = 1'b1;
                  end
               end
            end
            default: ; // Unmapped writes ignored
         endcase
      end

      // Master sequencer
      case (cur.state)
         ST_IDLE, ST_HOLD: begin
            // Start request from software
            if (next_cur.control_word[CON_START_BIT] &&
                  next_cur.state == cur.state) begin
               next_cur.pins.sda_oe = 1'b1; // Data low, clock free
               next_cur.pins.scl_oe = 1'b0;
               next_cur.state = ST_START;
               brg_load = 1'b1;
            end
         end
         ST_START: begin
            if (brg_tick) begin
               next_cur.pins.scl_oe = 1'b1;
               next_cur.control_word[CON_START_BIT] = 1'b0;
               next_cur.irq = 1'b1;
               next_cur.state = ST_HOLD;
            end
         end
         ST_LOW: begin
            // Data changes while clock is low
            if (cur.bit_cnt < 4'(BITS_PER_BYTE)) begin
               next_cur.pins.sda_oe = !cur.shift[7];
            end else begin
               next_cur.pins.sda_oe = 1'b0; // Released for answer
            end
            if (brg_tick) begin
               next_cur.pins.scl_oe = 1'b0;
               next_cur.state = ST_HIGH;
               // Counter stopped at zero; restart it for the high phase
               brg_load = 1'b1;
            end
         end
         ST_HIGH: begin
            // Baud count held while slave stretches
            if (!scl_in) begin
               brg_load = 1'b1;
            end else if (brg_tick) begin
               next_cur.pins.scl_oe = 1'b1; // Falling edge
               next_cur.shift = {cur.shift[6:0], 1'b0};
               next_cur.bit_cnt = cur.bit_cnt + 4'h1;
               next_cur.state = ST_LOW;
               brg_load = 1'b1;
               if (cur.bit_cnt == 4'(BITS_PER_BYTE - 1)) begin
                  next_cur.full_flag = 1'b0;
                  next_cur.pins.sda_oe = 1'b0;
               end else if (cur.bit_cnt == 4'(BITS_PER_BYTE)) begin
                  next_cur.ack_flag = sda_in;
                  next_cur.txbusy_flag = 1'b0;
                  next_cur.irq = 1'b1;
                  next_cur.state = ST_IDLE;
                  brg_load = 1'b0;
               end
            end
         end
         default: next_cur.state = ST_IDLE;
      endcase
   end

   // Baud generator reloads each cycle the clock is sampled low in the high phase; it counts from the first high sample
   // Register the whole state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
         cur.state <= ST_IDLE;
         cur.control_word <= CON_RESET;
         cur.baud_reload_value <= BAUD_RESET;
         cur.transmit_buffer <= TX_RESET;
         cur.scl_prev <= 1'b1;
         cur.sda_prev <= 1'b1;
         cur.stop_seen <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs from flip-flops, except waitrequest, which is gated by read and write; pins only ever pull low
   assign readdata = cur.rdata;
   assign waitrequest = (read || write) && !cur.ack_done;
   assign scl_out = cur.pins.scl_out;
   assign scl_oe = cur.pins.scl_oe;
   assign sda_out = cur.pins.sda_out;
   assign sda_oe = cur.pins.sda_oe;
   assign master_event_interrupt = cur.irq;

endmodule : i2m_master
`default_nettype wire

// ### src/i2m_pkg.sv
/*
 * Package for the I2C master start/transmit block: register offsets,
 * field positions, reset values, timing constants, state and bus types.
 * Assumes a 125 MHz system clock and an Avalon-MM slave with 32-bit data.
 */
package i2m_pkg;

   // Register byte addresses
   localparam logic [3:0] ADDR_CONTROL = 4'h0; // Control word
   localparam logic [3:0] ADDR_STATUS = 4'h4; // Status word
   localparam logic [3:0] ADDR_BAUD = 4'h8; // Baud reload value
   localparam logic [3:0] ADDR_TRANSMIT = 4'hC; // Transmit buffer

   // Control word fields
   localparam int CON_START_BIT = 0; // Start request bit
   localparam int CON_LOCK_BITS = 5; // Low bits frozen while busy
   localparam int CON_WIDTH = 16;

   // Status word fields
   localparam int STAT_FULL_BIT = 0; // Transmit full flag
   localparam int STAT_START_SEEN_BIT = 3; // Start seen
   localparam int STAT_STOP_SEEN_BIT = 4; // Stop seen
   localparam int STAT_COLL_BIT = 7; // Write collision flag
   localparam int STAT_TXBUSY_BIT = 14; // Transmit in progress
   localparam int STAT_ACK_BIT = 15; // Acknowledge status flag

   // Reset values
   localparam logic [15:0] CON_RESET = 16'h0000;
   localparam logic [15:0] BAUD_RESET = 16'h0002;
   localparam logic [7:0] TX_RESET = 8'hFF;

   // Timing: instruction cycle is two system clocks, baud count
   // decrements twice per instruction cycle, so once per clk.
   localparam int CLK_HZ = 125000000;
   localparam int TCY_NS = 16; // Instruction cycle time in ns
   localparam int TCY_CYCLES = (TCY_NS * CLK_HZ + 999999999) / 1000000000;
   localparam int DEC_PER_TCY = 2; // Baud decrements per instruction cycle
   localparam int BITS_PER_BYTE = 8;

   // Master sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, // Waiting for software
      ST_START = 3'b001, // Data low, clock high
      ST_LOW = 3'b010, // Clock low phase of a bit
      ST_HIGH = 3'b011, // Clock high phase of a bit
      ST_HOLD = 3'b100 // Clock held low after Start
   } i2m_state_t;

   // Bus pin bundle (two signals per open-drain pin)
   typedef struct packed {
      logic scl_out; // Level driven when enabled
      logic scl_oe; // High while pulling clock
      logic sda_out;
      logic sda_oe;
   } i2m_pins_t;

endpackage : i2m_pkg

// ### src/i2m_baud.sv
/*
 * Baud rate generator: loads the reload value and counts down once per
 * clock (twice per instruction cycle) to zero, then stops.
 * Assumes the caller pulses load and watches the timeout pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module i2m_baud
   import i2m_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic [15:0] reload,
   // Status
   output logic timeout
);

   // Whole state of the counter
   typedef struct packed {
      logic [15:0] count; // Remaining decrements
      logic run; // Counting
      logic tick; // Zero reached this cycle
   } i2m_baud_t;

   i2m_baud_t cur;
   i2m_baud_t next_cur;

   // Count down, flag zero once, then stop until reloaded
   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      if (load) begin
         next_cur.count = reload;
         next_cur.run = 1'b1;
      end else if (cur.run) begin
         if (cur.count == 16'h0000) begin
            next_cur.run = 1'b0;
            next_cur.tick = 1'b1;
         end else begin
            next_cur.count = cur.count - 16'h0001;
         end
      end
   end

   // Register the state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign timeout = cur.tick;

endmodule : i2m_baud
`default_nettype wire

// ### verif/i2m_checker.sv
/* Checker for the I2C master: bus answer, event pulse, line timing.
   Assumes it is bound to i2m_master and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module i2m_checker
   import i2m_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic waitrequest,
   // Bus pins
   input wire logic scl_in,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic master_event_interrupt
);
   logic [15:0] brg; // Reload value last written
   logic [15:0] lo_cnt; // Cycles clock pulled low
   logic [15:0] hi_cnt; // Cycles clock released and high
   logic held; // Low phase that follows an event has no fixed length
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Half-period counters; a data change restarts the high count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         brg <= BAUD_RESET;
         lo_cnt <= 16'h0000;
         hi_cnt <= 16'h0000;
         held <= 1'b0;
      end else begin
         if (write && !waitrequest && address == ADDR_BAUD) begin
            brg <= writedata[15:0];
         end
         lo_cnt <= scl_oe ? lo_cnt + 16'h0001 : 16'h0000;
         hi_cnt <= (!scl_oe && scl_in && !$changed(sda_oe)) ?
            hi_cnt + 16'h0001 : 16'h0000;
         if (master_event_interrupt) begin
            held <= 1'b1;
         end else if (!scl_oe) begin
            held <= 1'b0;
         end
      end
   end
   a_wait_once: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("waitrequest longer than one cycle");
   a_irq_single: assert property (master_event_interrupt |=>
      !master_event_interrupt) else $error("event pulse too long");
   a_irq_hold: assert property (master_event_interrupt |->
      scl_oe [*4]) else $error("clock not held low after event");
   a_start_low: assert property (master_event_interrupt && sda_oe |->
      (sda_oe && scl_oe) [*4]) else $error("lines not low after start");
   a_start_form: assert property ($rose(sda_oe) && !scl_oe |->
      !scl_oe [*3] ##[1:600] scl_oe) else $error("start shape wrong");
   a_data_stable: assert property ($changed(sda_oe) && !scl_oe &&
      !$past(scl_oe) |-> $rose(sda_oe)) else $error("data moved, clock high");
   a_low_time: assert property ($fell(scl_oe) && !held |->
      lo_cnt >= brg + 1 && lo_cnt <= brg + 3) else $error("low time wrong");
   a_high_time: assert property ($rose(scl_oe) |->
      hi_cnt >= brg && hi_cnt <= brg + 5) else $error("high time wrong");
endmodule : i2m_checker
bind i2m_master i2m_checker i2m_checker_i (.clk(clk), .nrst(nrst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .waitrequest(waitrequest), .scl_in(scl_in), .scl_oe(scl_oe),
   .sda_oe(sda_oe), .master_event_interrupt(master_event_interrupt));
`default_nettype wire

// ### verif/i2m_slave.sv
/* Slave model: takes bits on clock rise, answers on the ninth clock,
   stretches the clock. Assumes resolved lines with pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module i2m_slave
   import i2m_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Resolved lines and behaviour
   input wire logic scl,
   input wire logic sda,
   input wire logic nack,
   input wire logic [3:0] stretch,
   // Pulls and received byte
   output logic scl_low,
   output logic sda_low,
   output logic [7:0] rx
);
   logic scl_q; // Previous line levels, for edge finding
   logic sda_q;
   logic [3:0] nb; // Bits seen in this byte
   logic [3:0] hold; // Stretch cycles left
   // Sampled each clock; a released line falls back to its pull-up
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         nb <= 4'h0;
         hold <= 4'h0;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
         rx <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (scl && scl_q && sda_q && !sda) begin // Start seen
            nb <= 4'h0;
         end else if (scl && !scl_q) begin // Rising: take a bit
            if (nb < 4'h8) rx <= {rx[6:0], sda};
            nb <= nb + 4'h1;
         end else if (!scl && scl_q) begin // Falling: answer, reframe
            sda_low <= (nb == 4'h8) && !nack;
            if (nb == 4'h9) nb <= 4'h0;
         end
         if (!scl && scl_q) begin // Stretch after each falling edge
            hold <= stretch;
            scl_low <= (stretch != 4'h0);
         end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
            scl_low <= (hold > 4'h1);
         end
      end
   end
endmodule : i2m_slave
`default_nettype wire

// ### verif/tb_top.sv
/* Testbench: register sequences for Start, refused writes and bytes.
   Assumes the slave model and checker beside the design. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import i2m_pkg::*;
   logic clk, nrst, read, write, nack; // Bench-driven controls
   logic [3:0] address, byteenable, stretch;
   logic [31:0] writedata, readdata, rd;
   logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, irq;
   logic s_scl, s_sda; // Slave pulls
   logic [7:0] rx;
   wire logic scl_w, sda_w; // Resolved lines with pull-ups
   int err_total, n_tests;
   // Address, ten-bit prefix and second byte, then plain data
   // Read of a ten-bit slave needs a Repeated Start, left to software
   localparam logic [7:0] BYTES [4] =
      '{8'hA0, 8'hF6, 8'h2B, 8'h3C};
   assign scl_w = ~((scl_oe & ~scl_out) | s_scl);
   assign sda_w = ~((sda_oe & ~sda_out) | s_sda);
   i2m_master i2m_master_i (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .master_event_interrupt(irq));
   i2m_slave i2m_slave_i (.clk(clk), .nrst(nrst), .scl(scl_w), .sda(sda_w),
      .nack(nack), .stretch(stretch), .scl_low(s_scl), .sda_low(s_sda),
      .rx(rx));
   // One bus access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      if (n >= 50) err_total++;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         err_total++;
      end
   endtask : chk
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk
   // The event is a one-cycle pulse, so every edge is looked at
   task automatic wirq;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq !== 1'b1 && n < 5000);
      chk({31'h0, irq}, 32'h1);
   endtask : wirq
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, well beyond the expected run length
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   // Main sequence
   initial begin
      {nrst, read, write, nack, address, writedata} = '0;
      byteenable = 4'hF;
      stretch = 4'h0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rchk(ADDR_CONTROL, 32'h0);
      rchk(ADDR_BAUD, 32'h2);
      rchk(ADDR_STATUS, 32'h0);
      bus(1'b1, 4'h3, 32'hFFFF);
      rchk(4'h3, 32'h0);
      bus(1'b1, ADDR_BAUD, 32'h14);
      bus(1'b1, ADDR_CONTROL, 32'h1);
      bus(1'b1, ADDR_TRANSMIT, 32'h5A);
      bus(1'b1, ADDR_CONTROL, 32'h1E);
      rchk(ADDR_CONTROL, 32'h1);
      rchk(ADDR_STATUS, 32'h88);
      wirq();
      rchk(ADDR_CONTROL, 32'h0);
      chk({30'h0, scl_w, sda_w}, 32'h0);
      bus(1'b1, ADDR_STATUS, 32'h0);
      bus(1'b1, ADDR_BAUD, 32'h4);
      // Stretch grows past the low phase; last byte is refused by slave
      for (int i = 0; i < 4; i++) begin
         nack <= (i == 3);
         stretch <= 4'(i * 4);
         bus(1'b1, ADDR_TRANSMIT, {24'h0, BYTES[i]});
         rchk(ADDR_STATUS, 32'h4009);
         bus(1'b1, ADDR_TRANSMIT, 32'h55);
         rchk(ADDR_STATUS, 32'h4089);
         wirq();
         chk({24'h0, rx}, {24'h0, BYTES[i]});
         rchk(ADDR_STATUS, {16'h0, i == 3, 15'h0088});
         bus(1'b1, ADDR_STATUS, 32'h0);
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
